// >>> rtc_alarm_pkg.sv
// Constants, register map and state types for the time-of-day alarm block
package rtc_alarm_pkg;

    // ************************************************************
    // Bus and register map (word index, byte address = 4 * index)
    // ************************************************************
    localparam int ADDR_W = 8;                      // Byte address width
    localparam int IDX_W = 6;                       // Word index width
    localparam logic [5:0] IDX_CTRL = 6'h18;        // Enables
    localparam logic [5:0] IDX_STATUS = 6'h19;      // Alarm flag, busy
    localparam logic [5:0] IDX_SUBSEC = 6'h1a;      // subsecond_count
    localparam logic [5:0] IDX_SEC_HIGH = 6'h1b;    // seconds_count_high
    localparam logic [5:0] IDX_SEC_LOW = 6'h1c;     // seconds_count_low
    localparam logic [5:0] IDX_ALARM_HIGH = 6'h1e;  // alarm_tod_high
    localparam logic [5:0] IDX_ALARM_LOW = 6'h1f;   // alarm_tod_low
    localparam logic [1:0] RESP_OKAY = 2'h0;        // Normal answer
    localparam logic [1:0] RESP_SLVERR = 2'h2;      // Unmapped address

    // ************************************************************
    // Field positions and widths
    // ************************************************************
    localparam int CTRL_COUNT_EN_BIT = 0;           // rtc_count_enable
    localparam int CTRL_ALARM_EN_BIT = 1;           // alarm_tod_enable
    localparam int STAT_FLAG_BIT = 0;               // Sticky alarm flag
    localparam int STAT_BUSY_BIT = 1;               // Busy indication
    localparam int ALARM_HIGH_W = 4;                // Implemented high bits
    localparam int ALARM_LOW_W = 16;                // Low alarm width
    localparam int ALARM_CMP_W = 20;                // Compared bits
    localparam int SUBSEC_W = 8;                    // Subsecond width
    localparam int SEC_HALF_W = 16;                 // Each seconds half
    localparam logic [7:0] SUBSEC_LAST = 8'hff;     // Value before rollover

    // ************************************************************
    // Reset values and timing counts
    // ************************************************************
    localparam logic CTRL_RST = 1'b0;               // Enables off
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam int BUSY_W = 3;                      // Busy counter width
    localparam logic [2:0] BUSY_CYCLES = 3'h4;      // Busy after a write
    localparam int OSC_HZ = 32768;                  // Oscillator rate
    localparam int TICK_HZ = 256;                   // Subsecond tick rate
    localparam int DIV_COUNT = OSC_HZ / TICK_HZ;    // Edges per tick
    localparam int DIV_W = 7;                       // Divider width

    // ************************************************************
    // State records
    // ************************************************************
    typedef struct packed {
        logic sync0;                                // First sync stage
        logic sync1;                                // Second sync stage
        logic prev;                                 // Edge detect history
        logic [DIV_W-1:0] div;                      // Edge divider
        logic tick;                                 // One-cycle tick
    } presc_state_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;                               // Address held
        logic w_got;                                // Data held
        logic [IDX_W-1:0] aw_idx;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic rtc_count_enable;                     // Seconds counting on
        logic alarm_tod_enable;                     // Alarm compare on
        logic flag;                                 // Sticky alarm flag
        logic [BUSY_W-1:0] busy_cnt;                // Busy countdown
        logic [ALARM_HIGH_W-1:0] alarm_high;        // Battery backed
        logic [ALARM_LOW_W-1:0] alarm_low;          // Battery backed
        logic [SUBSEC_W-1:0] subsec;                // Battery backed
        logic [SEC_HALF_W-1:0] sec_high;            // Battery backed
        logic [SEC_HALF_W-1:0] sec_low;             // Battery backed
    } rtc_state_s;

endpackage : rtc_alarm_pkg

// >>> rtc_tick_prescaler.sv
// Oscillator synchroniser and divider producing the subsecond tick
`timescale 1ns/1ps

module rtc_tick_prescaler
    import rtc_alarm_pkg::*;
#(
    parameter int DIVIDE = DIV_COUNT                // Oscillator edges/tick
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic osc_i,                         // Slow oscillator pin
    output logic tick_o                             // One-cycle tick pulse
);

    presc_state_s r;                                // Registered state
    presc_state_s nxt;                              // Next state

    // ************************************************************
    // Next state
    // ************************************************************
    // Edge detect only reads the second stage; the first may be metastable
    always_comb begin
        nxt = r;
        nxt.sync0 = osc_i;
        nxt.sync1 = r.sync0;
        nxt.prev = r.sync1;
        nxt.tick = 1'b0;
        if (r.sync1 && !r.prev) begin
            if (r.div == DIV_W'(DIVIDE - 1)) begin
                nxt.div = '0;
                nxt.tick = 1'b1;
            end else begin
                nxt.div = r.div + DIV_W'(1);
            end
        end
        if (!nrst_i) begin
            nxt = '0;
        end
    end

    // ************************************************************
    // State register, frozen while the clock enable is low
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            r <= nxt;
        end
    end

    assign tick_o = r.tick;

endmodule : rtc_tick_prescaler

// >>> rtc_time_of_day_alarm.sv
// Time-of-day alarm with seconds counter behind an AXI4-Lite slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module rtc_time_of_day_alarm
    import rtc_alarm_pkg::*;
#(
    parameter int DIVIDE = DIV_COUNT                // Oscillator edges/tick
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic osc_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic alarm_flag_o                       // Sticky alarm level
);

    // ************************************************************
    // Declarations
    // ************************************************************
    rtc_state_s r;                                  // Registered state
    rtc_state_s nxt;                                // Next state
    logic tick;                                     // 256 Hz tick pulse
    logic do_write;                                 // Both halves held
    logic locked;                                   // Both enables set
    logic [31:0] wmask;                             // Byte lanes as bits
    logic [31:0] rd_word;                           // Read mux output
    logic [IDX_W-1:0] ar_idx;                       // Read word index
    logic [31:0] sec_now;                           // Seconds as one word

    // ************************************************************
    // Tick source
    // ************************************************************
    rtc_tick_prescaler #(.DIVIDE(DIVIDE)) u_presc (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .osc_i(osc_i),
        .tick_o(tick)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    // Byte strobes widened into a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[8*gi +: 8] = {8{r.w_strb[gi]}};
        end
    endgenerate

    assign do_write = r.aw_got && r.w_got && !r.bvalid;
    assign locked = r.alarm_tod_enable && r.rtc_count_enable;
    assign ar_idx = s_axi_araddr_i[ADDR_W-1:2];
    assign sec_now = {r.sec_high, r.sec_low};
    // Merge held write data into an old register value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    // ************************************************************
    // Read mux
    // ************************************************************
    // Alarm bits are readable whatever the enables or busy say
    always_comb begin
        rd_word = '0;
        case (ar_idx)
            IDX_CTRL: begin
                rd_word[CTRL_COUNT_EN_BIT] = r.rtc_count_enable;
                rd_word[CTRL_ALARM_EN_BIT] = r.alarm_tod_enable;
            end
            IDX_STATUS: begin
                rd_word[STAT_FLAG_BIT] = r.flag;
                rd_word[STAT_BUSY_BIT] = (r.busy_cnt != '0);
            end
            IDX_SUBSEC: rd_word[SUBSEC_W-1:0] = r.subsec;
            IDX_SEC_HIGH: rd_word[SEC_HALF_W-1:0] = r.sec_high;
            IDX_SEC_LOW: rd_word[SEC_HALF_W-1:0] = r.sec_low;
            // Upper bits stay zero by the default above
            IDX_ALARM_HIGH: rd_word[ALARM_HIGH_W-1:0] = r.alarm_high;
            IDX_ALARM_LOW: rd_word[ALARM_LOW_W-1:0] = r.alarm_low;
            default: rd_word = '0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [31:0] wv;                            // Merged write value
        logic [31:0] sec_inc;                       // Seconds plus one
        logic bump;                                 // Seconds advance
        wv = '0;
        sec_inc = sec_now + 32'h0000_0001;
        bump = 1'b0;
        nxt = r;

        // Busy counts down on its own
        if (r.busy_cnt != '0) begin
            nxt.busy_cnt = r.busy_cnt - BUSY_W'(1);
        end

        // Write address and data are taken in either order
        if (s_axi_awvalid_i && r.awready) begin
            nxt.aw_got = 1'b1;
            nxt.aw_idx = s_axi_awaddr_i[ADDR_W-1:2];
        end
        if (s_axi_wvalid_i && r.wready) begin
            nxt.w_got = 1'b1;
            nxt.w_data = s_axi_wdata_i;
            nxt.w_strb = s_axi_wstrb_i;
        end
        if (r.bvalid && s_axi_bready_i) begin
            nxt.bvalid = 1'b0;
        end

        // Counting; counter writes need the counter stopped, so no clash
        if (r.rtc_count_enable && tick) begin
            nxt.subsec = r.subsec + SUBSEC_W'(1);
            if (r.subsec == SUBSEC_LAST) begin
                bump = 1'b1;
                nxt.sec_high = sec_inc[31:16];
                nxt.sec_low = sec_inc[15:0];
            end
        end

        // Commit a held write; refused writes still answer OKAY
        if (do_write) begin
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = RESP_OKAY;
            case (r.aw_idx)
                IDX_CTRL: begin
                    wv = merge({30'h0, r.alarm_tod_enable,
                                r.rtc_count_enable}, r.w_data, wmask);
                    nxt.rtc_count_enable = wv[CTRL_COUNT_EN_BIT];
                    nxt.alarm_tod_enable = wv[CTRL_ALARM_EN_BIT];
                end
                IDX_STATUS: begin
                    // Write one to clear the alarm flag
                    if (r.w_strb[0] && r.w_data[STAT_FLAG_BIT]) begin
                        nxt.flag = 1'b0;
                    end
                end
                IDX_SUBSEC: begin
                    if (!r.rtc_count_enable && r.busy_cnt == '0) begin
                        wv = merge({24'h0, r.subsec}, r.w_data, wmask);
                        nxt.subsec = wv[SUBSEC_W-1:0];
                        nxt.busy_cnt = BUSY_CYCLES;
                    end
                end
                IDX_SEC_HIGH: begin
                    if (!r.rtc_count_enable && r.busy_cnt == '0) begin
                        wv = merge({16'h0, r.sec_high}, r.w_data, wmask);
                        nxt.sec_high = wv[SEC_HALF_W-1:0];
                        nxt.busy_cnt = BUSY_CYCLES;
                    end
                end
                IDX_SEC_LOW: begin
                    if (!r.rtc_count_enable && r.busy_cnt == '0) begin
                        wv = merge({16'h0, r.sec_low}, r.w_data, wmask);
                        nxt.sec_low = wv[SEC_HALF_W-1:0];
                        nxt.busy_cnt = BUSY_CYCLES;
                    end
                end
                IDX_ALARM_HIGH: begin
                    // Bits 7:4 are never stored
                    if (!locked) begin
                        wv = merge({28'h0, r.alarm_high}, r.w_data, wmask);
                        nxt.alarm_high = wv[ALARM_HIGH_W-1:0];
                    end
                end
                IDX_ALARM_LOW: begin
                    if (!locked && r.busy_cnt == '0) begin
                        wv = merge({16'h0, r.alarm_low}, r.w_data, wmask);
                        nxt.alarm_low = wv[ALARM_LOW_W-1:0];
                        nxt.busy_cnt = BUSY_CYCLES;
                    end
                end
                default: nxt.bresp = RESP_SLVERR;
            endcase
        end

        // Alarm after the clear so a same-cycle event is kept
        if (bump && r.alarm_tod_enable &&
            {r.alarm_high, r.alarm_low} == sec_inc[ALARM_CMP_W-1:0]) begin
            nxt.flag = 1'b1;
        end

        // Read channel: one read in flight
        if (s_axi_arvalid_i && r.arready) begin
            nxt.rvalid = 1'b1;
            nxt.rdata = rd_word;
            nxt.rresp = (rd_word == '0 && !(ar_idx inside {IDX_CTRL,
                IDX_STATUS, IDX_SUBSEC, IDX_SEC_HIGH, IDX_SEC_LOW,
                IDX_ALARM_HIGH, IDX_ALARM_LOW})) ? RESP_SLVERR : RESP_OKAY;
        end
        if (r.rvalid && s_axi_rready_i) begin
            nxt.rvalid = 1'b0;
        end

        // Ready strobes follow the held state, so they come from flops
        nxt.awready = !nxt.aw_got && !nxt.bvalid;
        nxt.wready = !nxt.w_got && !nxt.bvalid;
        nxt.arready = !nxt.rvalid;

        // Reset spares the battery-backed alarm and counters
        if (!nrst_i) begin
            nxt.awready = 1'b1;
            nxt.wready = 1'b1;
            nxt.arready = 1'b1;
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.aw_idx = '0;
            nxt.w_data = '0;
            nxt.w_strb = '0;
            nxt.bvalid = 1'b0;
            nxt.bresp = RESP_OKAY;
            nxt.rvalid = 1'b0;
            nxt.rresp = RESP_OKAY;
            nxt.rdata = RDATA_RST;
            nxt.rtc_count_enable = CTRL_RST;
            nxt.alarm_tod_enable = CTRL_RST;
            nxt.flag = 1'b0;
            nxt.busy_cnt = '0;
        end
    end

    // ************************************************************
    // State register, frozen while the clock enable is low
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            r <= nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign s_axi_awready_o = r.awready;
    assign s_axi_wready_o = r.wready;
    assign s_axi_bresp_o = r.bresp;
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_arready_o = r.arready;
    assign s_axi_rdata_o = r.rdata;
    assign s_axi_rresp_o = r.rresp;
    assign s_axi_rvalid_o = r.rvalid;
    assign alarm_flag_o = r.flag;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    high_wr_gate_a: assert property (disable iff (!nrst_i)
        (ce_i && do_write && r.aw_idx == IDX_ALARM_HIGH && locked)
        |=> $stable(r.alarm_high))
        else $error("high alarm changed while locked");
    high_rsvd_zero_a: assert property (disable iff (!nrst_i)
        (ce_i && s_axi_arvalid_i && s_axi_arready_o &&
         ar_idx == IDX_ALARM_HIGH) |=> (s_axi_rdata_o[31:4] == 28'h0))
        else $error("high alarm upper bits not zero");
    low_wr_gate_a: assert property (disable iff (!nrst_i)
        (ce_i && do_write && r.aw_idx == IDX_ALARM_LOW &&
         (locked || r.busy_cnt != '0)) |=> $stable(r.alarm_low))
        else $error("low alarm changed while refused");
    low_wr_take_a: assert property (disable iff (!nrst_i)
        (ce_i && do_write && r.aw_idx == IDX_ALARM_LOW && !locked &&
         r.busy_cnt == '0 && r.w_strb == 4'hf)
        |=> (r.alarm_low == $past(r.w_data[15:0]) &&
             r.busy_cnt == BUSY_CYCLES))
        else $error("low alarm write not taken");
    alarm_fire_a: assert property (disable iff (!nrst_i)
        (ce_i && locked && tick && r.subsec == SUBSEC_LAST &&
         {r.alarm_high, r.alarm_low} == 20'(sec_now + 32'h1))
        |=> alarm_flag_o)
        else $error("alarm did not fire on match");
    sec_roll_a: assert property (disable iff (!nrst_i)
        (ce_i && r.rtc_count_enable && tick && r.subsec == SUBSEC_LAST)
        |=> ({r.sec_high, r.sec_low} == $past(sec_now) + 32'h1 &&
             r.subsec == 8'h00))
        else $error("seconds did not advance on rollover");
    sub_step_a: assert property (disable iff (!nrst_i)
        (ce_i && r.rtc_count_enable && tick && r.subsec != SUBSEC_LAST)
        |=> (r.subsec == $past(r.subsec) + 8'h01 && $stable(sec_now)))
        else $error("subsecond did not step");
    reset_keep_a: assert property (
        (!nrst_i && ce_i && $past(nrst_i)) |=>
        ($stable(r.alarm_high) && $stable(r.alarm_low)))
        else $error("alarm lost through reset");
    read_any_a: assert property (disable iff (!nrst_i)
        (ce_i && s_axi_arvalid_i && s_axi_arready_o &&
         ar_idx == IDX_ALARM_LOW)
        |=> (s_axi_rvalid_o && s_axi_rdata_o[15:0] == $past(r.alarm_low)))
        else $error("low alarm read mismatch");
    flag_sticky_a: assert property (disable iff (!nrst_i)
        (alarm_flag_o && !(do_write && r.aw_idx == IDX_STATUS))
        |=> alarm_flag_o)
        else $error("alarm flag dropped without clear");
    wr_answer_c: cover property (disable iff (!nrst_i)
        do_write && r.aw_idx == IDX_ALARM_HIGH && !locked ##1 s_axi_bvalid_o);
    alarm_fire_c: cover property (disable iff (!nrst_i)
        !alarm_flag_o ##1 alarm_flag_o);
    busy_refuse_c: cover property (disable iff (!nrst_i)
        do_write && r.aw_idx == IDX_ALARM_LOW && r.busy_cnt != '0);
    flag_clear_c: cover property (disable iff (!nrst_i)
        alarm_flag_o ##1 !alarm_flag_o);
endmodule : rtc_time_of_day_alarm

// >>> tb_rtc_time_of_day_alarm.sv
// Register-level testbench for the time-of-day alarm block
`timescale 1ns/1ps

module tb_rtc_time_of_day_alarm;
    import rtc_alarm_pkg::*;

    // ************************************************************
    // Stimulus signals and counters
    // ************************************************************
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic osc_i = 1'b0;                    // Slow oscillator, clk/8
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, flag;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [1:0] rsp;
    int miscompares = 0, total_checks = 0, cyc = 0;

    always #50 clk_i = ~clk_i;
    always #400 osc_i = ~osc_i;            // Four clocks high and low

    // Small divider keeps a simulated second near four thousand clocks
    rtc_time_of_day_alarm #(.DIVIDE(2)) dut (.clk_i(clk_i),
        .nrst_i(nrst_i), .ce_i(1'b1), .osc_i(osc_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .alarm_flag_o(flag));

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Write one word; address and data offered together, held until taken
    task automatic wr(input logic [5:0] idx, input logic [31:0] d,
                      input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk_i);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (bvalid && ad && wd) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                break;
            end
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
    endtask : wr

    // Read one word; arvalid dropped once taken, rready held until rvalid
    task automatic rdw(input logic [5:0] idx, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clk_i);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (rvalid && !arvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end
    endtask : rdw

    task automatic rchk(input string n, input logic [5:0] idx,
                        input logic [31:0] e);
        rdw(idx, rd, rsp);
        chk(n, rd, e);
    endtask : rchk

    // Poll status until busy clears; bounded by the global timeout
    task automatic idle;
        do rdw(IDX_STATUS, rd, rsp); while (rd[STAT_BUSY_BIT] !== 1'b0);
    endtask : idle

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        rchk("ctrl", IDX_CTRL, 32'h0);
        rdw(6'h00, rd, rsp);
        chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(6'h00, 32'h1, RESP_SLVERR);
        $display("test reset and map done");
        // Counters set so the next second is 0x1000a in its low 20 bits
        wr(IDX_SEC_HIGH, 32'hfff1, RESP_OKAY);
        idle();
        wr(IDX_SEC_LOW, 32'h0009, RESP_OKAY);
        idle();
        wr(IDX_SUBSEC, 32'hf0, RESP_OKAY);
        idle();
        wr(IDX_ALARM_HIGH, 32'hf1, RESP_OKAY);
        rchk("alarm high", IDX_ALARM_HIGH, 32'h01);
        wr(IDX_ALARM_LOW, 32'h000a, RESP_OKAY);
        wr(IDX_ALARM_LOW, 32'h0bad, RESP_OKAY);
        idle();
        rchk("alarm low", IDX_ALARM_LOW, 32'h000a);
        $display("test alarm setup done");
        wr(IDX_CTRL, 32'h3, RESP_OKAY);
        chk("flag early", {31'h0, flag}, 32'h0);
        wr(IDX_ALARM_HIGH, 32'h0e, RESP_OKAY);
        wr(IDX_ALARM_LOW, 32'h5555, RESP_OKAY);
        rchk("gated high", IDX_ALARM_HIGH, 32'h01);
        rchk("gated low", IDX_ALARM_LOW, 32'h000a);
        $display("test write gating done");
        while (flag !== 1'b1) @(posedge clk_i);
        rchk("sec low", IDX_SEC_LOW, 32'h000a);
        rchk("sec high", IDX_SEC_HIGH, 32'hfff1);
        rchk("status", IDX_STATUS, 32'h1);
        wr(IDX_CTRL, 32'h0, RESP_OKAY);
        wr(IDX_STATUS, 32'h1, RESP_OKAY);
        rchk("status cleared", IDX_STATUS, 32'h0);
        $display("test alarm match done");
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rchk("kept high", IDX_ALARM_HIGH, 32'h01);
        rchk("kept low", IDX_ALARM_LOW, 32'h000a);
        $display("test reset retention done");
        end_sim();
    end

endmodule : tb_rtc_time_of_day_alarm
